/* File: pkg/edac_consts.svh */
// edac_consts.svh: constants for the non-volatile data access controller
// assumes inclusion by the package and the rtl files by bare name
`ifndef EDAC_CONSTS_SVH
`define EDAC_CONSTS_SVH

// ==========================================================
// register map
`define EDAC_CTRL_OFFSET 8'h40
`define EDAC_ADDR_OFFSET 8'h1E
`define EDAC_DATA_OFFSET 8'h1F
`define EDAC_BP_OFFSET 8'h04
`define EDAC_PTR_OFFSET 8'h03
`define EDAC_IAR_OFFSET 8'h02
`define EDAC_CTRL_BANK 1'h1

// ==========================================================
// control fields
`define EDAC_BIT_WPERMIT 3
`define EDAC_BIT_WSTART 2
`define EDAC_BIT_RPERMIT 1
`define EDAC_BIT_RSTART 0

// ==========================================================
// reset values
`define EDAC_ADDR_RESET 5'h00
`define EDAC_DATA_RESET 8'h00
`define EDAC_CTRL_RESET 4'h0
`define EDAC_BP_RESET 1'h0
`define EDAC_PTR_RESET 8'h00

// ==========================================================
// timing
`define EDAC_READ_CYCLES 4
`define EDAC_WRITE_TICKS 16
`define EDAC_TIMER_DIV 8

`endif

/* File: pkg/edac_pkg.sv */
// edac_pkg.sv: types shared by the controller files
// assumes edac_consts.svh is on the include path
package edac_pkg;
`include "edac_consts.svh"

    typedef struct packed
    {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } edac_sfr_s;

    typedef struct packed
    {
        logic write_permit;
        logic wstart;
        logic read_permit;
        logic rstart;
    } edac_ctrl_s;

    typedef enum logic [2:0]
    {
        EDAC_IDLE = 3'h1,
        EDAC_READ = 3'h2,
        EDAC_WRITE = 3'h4
    } edac_state_e;
endpackage

/* File: rtl/edac_ctrl.sv */
// edac_ctrl.sv: register-side controller for the 32-byte data store
// assumes a core that drives single-cycle sfr reads and writes, synchronous
// Function
// [R1] 32 bytes, one byte per access
// [R2] address register: 5 bits, upper zero
// [R3] data register 8 bits, resets zero
// [R4] address and data reachable directly
// [R5] control at 40H bank 1, indirect
// [R6] write permit zero refuses writes
// [R7] write start needs permit; self-clears
// [R8] read permit zero refuses reads
// [R9] read start needs permit; self-clears
// [R10] software sets permits before starts
// [R11] software never sets both starts
// [R12] read: permit, address, start, poll
// [R13] read data loaded before start clears
// [R14] data held until next access
// [R15] write: permit, address, data, start
// [R16] write length set by own timer
// [R17] completion: start clears, request raised
// [R18] reset clears permit and bank
// [R19] software keeps write permit cleared
// [R20] done flag set, cleared on service
// [R21] write start right after permit
// [R22] bank bit steers indirect accesses
// [R23] read takes fixed parameter cycles
// [R24] write length parameter, synchronised done
// [R25] cycle latches location and byte
`timescale 1ns/1ps
`include "edac_consts.svh"
module edac_ctrl
    import edac_pkg::*;
#(
    parameter int DEPTH = 32,
    parameter int READ_CYCLES = `EDAC_READ_CYCLES,
    parameter int WRITE_TICKS = `EDAC_WRITE_TICKS,
    parameter int TIMER_DIV = `EDAC_TIMER_DIV
)
(
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire edac_sfr_s sfr,
    input wire logic irq_ack,
    output logic [7:0] sfr_rdata,
    output logic write_done_flag,
    output logic busy
);
    localparam int AW = $clog2(DEPTH);

    logic [AW-1:0] rom_address_reg;
    logic [7:0] rom_data_reg;
    edac_ctrl_s rom_control_reg;
    logic bank_select_bit;
    logic [7:0] indirect_pointer_one;
    edac_state_e state_reg;
    edac_state_e state_next;
    logic [7:0] rcnt_reg;
    logic [AW-1:0] cyc_addr_reg;
    logic [7:0] cyc_data_reg;
    logic flag_reg;
    logic [7:0] store_rdata;
    logic wdone;
    logic store_we;

    // ==========================================================
    // address decode
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction

    wire ctrl_sel = hit(sfr.addr, `EDAC_IAR_OFFSET) && bank_select_bit == `EDAC_CTRL_BANK
        && indirect_pointer_one == `EDAC_CTRL_OFFSET; // [R5] [R22]
    wire ctrl_wr = sfr.wr && ctrl_sel;
    wire addr_wr = sfr.wr && hit(sfr.addr, `EDAC_ADDR_OFFSET); // [R4]
    wire data_wr = sfr.wr && hit(sfr.addr, `EDAC_DATA_OFFSET); // [R4]
    wire bp_wr = sfr.wr && hit(sfr.addr, `EDAC_BP_OFFSET);
    wire ptr_wr = sfr.wr && hit(sfr.addr, `EDAC_PTR_OFFSET);
    wire idle = (state_reg == EDAC_IDLE);
    wire go_write = idle && ctrl_wr && sfr.wdata[`EDAC_BIT_WSTART]
        && rom_control_reg.write_permit; // [R6] [R7]
    wire go_read = idle && ctrl_wr && sfr.wdata[`EDAC_BIT_RSTART] && !go_write
        && rom_control_reg.read_permit; // [R8] [R9]
    wire read_end = (state_reg == EDAC_READ) && rcnt_reg == 8'(READ_CYCLES - 1); // [R23]
    wire write_end = (state_reg == EDAC_WRITE) && wdone; // [R24]

    // ==========================================================
    // state machine
    always_comb
    begin
        case (state_reg)
            EDAC_IDLE: state_next = go_write ? EDAC_WRITE : (go_read ? EDAC_READ : EDAC_IDLE);
            EDAC_READ: state_next = read_end ? EDAC_IDLE : EDAC_READ;
            EDAC_WRITE: state_next = write_end ? EDAC_IDLE : EDAC_WRITE;
            default: state_next = EDAC_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
            state_reg <= EDAC_IDLE;
        else
            state_reg <= state_next;
    end

    always_ff @(posedge ref_clk)
    begin
        if (!reset_n || idle)
            rcnt_reg <= 8'h00;
        else if (state_reg == EDAC_READ)
            rcnt_reg <= rcnt_reg + 8'h01;
    end

    // ==========================================================
    // cycle latches, immune to later register writes
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            cyc_addr_reg <= `EDAC_ADDR_RESET;
            cyc_data_reg <= `EDAC_DATA_RESET;
        end
        else if (go_write || go_read)
        begin
            cyc_addr_reg <= rom_address_reg; // [R25]
            cyc_data_reg <= rom_data_reg; // [R25]
        end
    end

    // ==========================================================
    // registers
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
            rom_address_reg <= `EDAC_ADDR_RESET; // [R2]
        else if (addr_wr)
            rom_address_reg <= sfr.wdata[AW-1:0]; // [R2]
    end

    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
            rom_data_reg <= `EDAC_DATA_RESET; // [R3]
        else if (read_end)
            rom_data_reg <= store_rdata; // [R13] [R14]
        else if (data_wr)
            rom_data_reg <= sfr.wdata; // [R3]
    end

    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            bank_select_bit <= `EDAC_BP_RESET; // [R18]
            indirect_pointer_one <= `EDAC_PTR_RESET;
        end
        else
        begin
            if (bp_wr)
                bank_select_bit <= sfr.wdata[0];
            if (ptr_wr)
                indirect_pointer_one <= sfr.wdata;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
            rom_control_reg <= `EDAC_CTRL_RESET; // [R18]
        else
        begin
            if (ctrl_wr)
            begin
                rom_control_reg.write_permit <= sfr.wdata[`EDAC_BIT_WPERMIT];
                rom_control_reg.read_permit <= sfr.wdata[`EDAC_BIT_RPERMIT];
            end
            rom_control_reg.wstart <= (state_next == EDAC_WRITE); // [R7] [R17]
            rom_control_reg.rstart <= (state_next == EDAC_READ); // [R9] [R13]
        end
    end

    // completion request: set wins over service
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
            flag_reg <= 1'b0;
        else if (write_end)
            flag_reg <= 1'b1; // [R20] [R17]
        else if (irq_ack)
            flag_reg <= 1'b0; // [R20]
    end

    // ==========================================================
    // store and timer
    assign store_we = write_end; // [R1]

    edac_store #(.DEPTH(DEPTH), .AW(AW)) u_store
    (
        .ref_clk(ref_clk),
        .we(store_we),
        .addr(cyc_addr_reg),
        .wdata(cyc_data_reg),
        .rdata(store_rdata)
    );

    edac_wtimer #(.TICKS(WRITE_TICKS), .DIV(TIMER_DIV)) u_timer // [R16]
    (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .start(go_write),
        .done(wdone)
    );

    // ==========================================================
    // read mux
    wire [7:0] ctrl_rd = {4'h0, rom_control_reg};
    assign sfr_rdata = hit(sfr.addr, `EDAC_ADDR_OFFSET) ? 8'(rom_address_reg) :
        hit(sfr.addr, `EDAC_DATA_OFFSET) ? rom_data_reg :
        hit(sfr.addr, `EDAC_BP_OFFSET) ? {7'h00, bank_select_bit} :
        hit(sfr.addr, `EDAC_PTR_OFFSET) ? indirect_pointer_one :
        ctrl_sel ? ctrl_rd : 8'h00;
    assign write_done_flag = flag_reg;
    assign busy = !idle;

    // ==========================================================
    // checks
    property p_wr_refused;
        @(posedge ref_clk) disable iff (!reset_n)
        (ctrl_wr && !rom_control_reg.write_permit && idle) |=> !rom_control_reg.wstart;
    endproperty
    a_wr_refused: assert property (p_wr_refused) else $error("write started without permit"); // [R6]

    property p_rd_refused;
        @(posedge ref_clk) disable iff (!reset_n)
        (ctrl_wr && !rom_control_reg.read_permit && idle) |=> !rom_control_reg.rstart;
    endproperty
    a_rd_refused: assert property (p_rd_refused) else $error("read started without permit"); // [R8]

    property p_rd_len;
        @(posedge ref_clk) disable iff (!reset_n)
        $rose(rom_control_reg.rstart) |-> rom_control_reg.rstart[*4] ##1 !rom_control_reg.rstart;
    endproperty
    a_rd_len: assert property (p_rd_len) else $error("read length wrong"); // [R23] [R9]

    property p_rd_data;
        @(posedge ref_clk) disable iff (!reset_n)
        $fell(rom_control_reg.rstart) |-> rom_data_reg == u_store.mem_reg[cyc_addr_reg];
    endproperty
    a_rd_data: assert property (p_rd_data) else $error("read data not loaded"); // [R13]

    property p_wr_flag;
        @(posedge ref_clk) disable iff (!reset_n)
        $fell(rom_control_reg.wstart) |-> write_done_flag;
    endproperty
    a_wr_flag: assert property (p_wr_flag) else $error("no completion request"); // [R17] [R20]

    property p_wr_bound;
        @(posedge ref_clk) disable iff (!reset_n)
        $rose(rom_control_reg.wstart) |-> ##[1:200] !rom_control_reg.wstart;
    endproperty
    a_wr_bound: assert property (p_wr_bound) else $error("write never ends"); // [R16] [R24]

    property p_one_kind;
        @(posedge ref_clk) disable iff (!reset_n)
        !(rom_control_reg.wstart && rom_control_reg.rstart);
    endproperty
    a_one_kind: assert property (p_one_kind) else $error("both cycles active"); // [R7] [R9]

    property p_hold;
        @(posedge ref_clk) disable iff (!reset_n)
        (busy && !read_end) |=> $stable(cyc_addr_reg) && $stable(cyc_data_reg);
    endproperty
    a_hold: assert property (p_hold) else $error("cycle latch changed"); // [R25]

    property p_data_keep;
        @(posedge ref_clk) disable iff (!reset_n)
        (!data_wr && !read_end) |=> $stable(rom_data_reg);
    endproperty
    a_data_keep: assert property (p_data_keep) else $error("data register changed"); // [R14]

    property p_flag_wins;
        @(posedge ref_clk) disable iff (!reset_n)
        write_end |=> write_done_flag;
    endproperty
    a_flag_wins: assert property (p_flag_wins) else $error("completion request lost"); // [R20]

    property p_flag_clr;
        @(posedge ref_clk) disable iff (!reset_n)
        (irq_ack && !write_end) |=> !write_done_flag;
    endproperty
    a_flag_clr: assert property (p_flag_clr) else $error("completion request not cleared"); // [R20]

    property p_addr_upper;
        @(posedge ref_clk) disable iff (!reset_n)
        hit(sfr.addr, `EDAC_ADDR_OFFSET) |-> (sfr_rdata >> AW) == 8'h00;
    endproperty
    a_addr_upper: assert property (p_addr_upper) else $error("address upper bits not zero"); // [R2]

    property p_ctrl_hidden;
        @(posedge ref_clk) disable iff (!reset_n)
        (hit(sfr.addr, `EDAC_IAR_OFFSET) && !ctrl_sel) |-> sfr_rdata == 8'h00;
    endproperty
    a_ctrl_hidden: assert property (p_ctrl_hidden) else $error("control visible outside bank one"); // [R5] [R22]

    c_read: cover property (@(posedge ref_clk) disable iff (!reset_n) $fell(rom_control_reg.rstart));
    c_write: cover property (@(posedge ref_clk) disable iff (!reset_n) $fell(rom_control_reg.wstart));
    c_refuse: cover property (@(posedge ref_clk) disable iff (!reset_n)
        ctrl_wr && sfr.wdata[`EDAC_BIT_WSTART] && !rom_control_reg.write_permit);
    c_set_wins: cover property (@(posedge ref_clk) disable iff (!reset_n) write_end && irq_ack);
    c_hidden: cover property (@(posedge ref_clk) disable iff (!reset_n)
        hit(sfr.addr, `EDAC_IAR_OFFSET) && !ctrl_sel);
endmodule

/* File: rtl/edac_store.sv */
// edac_store.sv: 32 x 8 non-volatile storage array modelled in flip-flops
// assumes one write strobe per cycle from the controller
`timescale 1ns/1ps
module edac_store
    import edac_pkg::*;
#(
    parameter int DEPTH = 32,
    parameter int AW = 5
)
(
    input wire logic ref_clk,
    input wire logic we,
    input wire logic [AW-1:0] addr,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata
);
    logic [7:0] mem_reg [DEPTH];

    // ==========================================================
    // storage: kept through reset, as non-volatile cells are
    always_ff @(posedge ref_clk)
    begin
        if (we)
            mem_reg[addr] <= wdata;
    end

    assign rdata = mem_reg[addr];
endmodule

/* File: rtl/edac_wtimer.sv */
// edac_wtimer.sv: write-cycle timer on its own slow tick
// assumes start is a one-cycle pulse; the tick is a divided enable
`timescale 1ns/1ps
`include "edac_consts.svh"
module edac_wtimer
    import edac_pkg::*;
#(
    parameter int TICKS = `EDAC_WRITE_TICKS,
    parameter int DIV = `EDAC_TIMER_DIV
)
(
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic start,
    output logic done
);
    logic [15:0] div_reg;
    logic [15:0] cnt_reg;
    logic busy_reg;
    logic tick;
    logic done_reg;

    // ==========================================================
    // free-running divider, unrelated in phase to the write start
    assign tick = (div_reg == 16'(DIV - 1));

    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
            div_reg <= 16'h0000;
        else if (tick)
            div_reg <= 16'h0000;
        else
            div_reg <= div_reg + 16'h0001;
    end

    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            busy_reg <= 1'b0;
            cnt_reg <= 16'h0000;
            done_reg <= 1'b0;
        end
        else
        begin
            done_reg <= 1'b0;
            if (start)
            begin
                busy_reg <= 1'b1;
                cnt_reg <= 16'h0000;
            end
            else if (busy_reg && tick)
            begin
                if (cnt_reg == 16'(TICKS - 1))
                begin
                    busy_reg <= 1'b0;
                    done_reg <= 1'b1;
                end
                else
                    cnt_reg <= cnt_reg + 16'h0001;
            end
        end
    end

    assign done = done_reg;
endmodule

/* File: sim/edac_core_model.sv */
// edac_core_model.sv: core-side model issuing sfr byte accesses
// assumes a controller answering sfr reads combinationally on addr
`timescale 1ns/1ps
`include "edac_consts.svh"
module edac_core_model
    import edac_pkg::*;
(
    input wire logic ref_clk,
    input wire logic [7:0] sfr_rdata,
    output edac_sfr_s sfr
);
    initial sfr = '0;

    // ==========================================================
    // single bus cycles
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        #10;
        sfr = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge ref_clk);
        #10;
        sfr.wr = 1'b0;
        sfr.wdata = ~d;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        #10;
        sfr = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        // settled answer, taken well clear of the launching edge
        #80;
        d = sfr_rdata;
        @(posedge ref_clk);
    endtask

    // ==========================================================
    // control access sequences
    task automatic open(input logic b);
        wr(`EDAC_PTR_OFFSET, `EDAC_CTRL_OFFSET);
        wr(`EDAC_BP_OFFSET, {7'h00, b});
    endtask

    // permit first, start in the very next write, one start only
    task automatic start(input logic [7:0] p, input logic [7:0] go);
        wr(`EDAC_IAR_OFFSET, p);
        wr(`EDAC_IAR_OFFSET, p | go);
    endtask

    task automatic close;
        wr(`EDAC_IAR_OFFSET, 8'h00);
    endtask
endmodule

/* File: sim/eeprom_data_access_ctrl_tb.sv */
// eeprom_data_access_ctrl_tb.sv: self-checking bench for the data store controller
// assumes edac_pkg and the core model are compiled first
`timescale 1ns/1ps
`include "edac_consts.svh"
module eeprom_data_access_ctrl_tb;
    import edac_pkg::*;
    localparam int RC = 4;
    localparam int WT = 2;
    localparam int TD = 2;
    localparam logic [7:0] ADR = `EDAC_ADDR_OFFSET;
    localparam logic [7:0] DAT = `EDAC_DATA_OFFSET;
    localparam logic [7:0] IAR = `EDAC_IAR_OFFSET;
    typedef struct {logic [7:0] a; logic [7:0] d;} edac_row_s;
    edac_row_s rows [4] = '{'{8'h00, 8'hA5}, '{8'h1F, 8'h5A}, '{8'hE3, 8'hFF}, '{8'h10, 8'h00}};
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic irq_ack = 1'b0;
    edac_sfr_s sfr;
    logic [7:0] sfr_rdata;
    logic [7:0] v;
    logic write_done_flag;
    logic busy;
    int bad_count = 0;
    int checks_done = 0;
    int n;

    always #50 ref_clk = ~ref_clk;

    edac_ctrl #(.READ_CYCLES(RC), .WRITE_TICKS(WT), .TIMER_DIV(TD)) DUT (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .sfr(sfr),
        .irq_ack(irq_ack),
        .sfr_rdata(sfr_rdata),
        .write_done_flag(write_done_flag),
        .busy(busy)
    );

    edac_core_model core (
        .ref_clk(ref_clk),
        .sfr_rdata(sfr_rdata),
        .sfr(sfr)
    );

    // ==========================================================
    // compare and helper tasks
    task automatic chk8(input string s, input logic [7:0] e, input logic [7:0] g);
        checks_done++;
        if (g !== e)
        begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", s, e, g);
        end
    endtask

    task automatic chkn(input string s, input int lo, input int hi, input int g);
        checks_done++;
        if (g < lo || g > hi)
        begin
            bad_count++;
            $display("wrong value %s expected %0d..%0d seen %0d", s, lo, hi, g);
        end
    endtask

    task automatic rchk(input logic [7:0] a, input string s, input logic [7:0] e);
        core.rd(a, v);
        chk8(s, e, v);
    endtask

    // counts cycles with a store cycle running, bounded
    task automatic cycles;
        n = 0;
        while (busy === 1'b1 && n < 200)
        begin
            @(posedge ref_clk);
            #10;
            n++;
        end
    endtask

    task automatic ack;
        @(posedge ref_clk);
        #10;
        irq_ack = 1'b1;
        @(posedge ref_clk);
        #10;
        irq_ack = 1'b0;
    endtask

    task automatic summarize;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial
    begin
        #2000000;
        bad_count++;
        summarize();
    end

    // ==========================================================
    // main sequence
    initial
    begin
        repeat (12) @(posedge ref_clk);
        #10;
        reset_n = 1'b1;
        core.open(1'b1);
        foreach (rows[i])
        begin
            core.wr(ADR, rows[i].a);
            rchk(ADR, "addr", rows[i].a & 8'h1F);
            core.wr(DAT, rows[i].d);
            core.start(8'h08, 8'h04);
            cycles();
            chkn("write len", (WT - 1) * TD, WT * TD + 2, n);
            chk8("flag set", 8'h01, {7'h00, write_done_flag});
            rchk(IAR, "ctrl wr", 8'h08);
            ack();
            chk8("flag clr", 8'h00, {7'h00, write_done_flag});
        end
        foreach (rows[i])
        begin
            core.wr(DAT, ~rows[i].d);
            core.wr(ADR, rows[i].a);
            core.start(8'h02, 8'h01);
            cycles();
            chkn("read len", RC, RC, n);
            rchk(IAR, "ctrl rd", 8'h02);
            rchk(DAT, "rdata", rows[i].d);
        end
        repeat (5) @(posedge ref_clk);
        core.wr(ADR, 8'h10);
        rchk(DAT, "held", rows[3].d);
        // refusals: start without permit, start with permit in one write
        core.wr(ADR, 8'h00);
        core.wr(DAT, 8'h77);
        core.close();
        core.wr(IAR, 8'h04);
        chk8("busy w", 8'h00, {7'h00, busy});
        core.wr(IAR, 8'h01);
        chk8("busy r", 8'h00, {7'h00, busy});
        rchk(DAT, "no read", 8'h77);
        core.wr(IAR, 8'h0C);
        rchk(IAR, "one-shot w", 8'h08);
        core.wr(IAR, 8'h03);
        rchk(IAR, "one-shot r", 8'h02);
        core.start(8'h02, 8'h01);
        cycles();
        rchk(DAT, "no write", 8'hA5);
        // location and byte latched at start
        core.wr(ADR, 8'h10);
        core.wr(DAT, 8'h3C);
        core.start(8'h08, 8'h04);
        core.wr(ADR, 8'h11);
        core.wr(DAT, 8'h99);
        cycles();
        ack();
        core.wr(ADR, 8'h10);
        core.start(8'h02, 8'h01);
        cycles();
        rchk(DAT, "latched", 8'h3C);
        // bank 0 hides the control register
        core.wr(IAR, 8'h08);
        core.open(1'b0);
        rchk(IAR, "bank0 rd", 8'h00);
        core.wr(IAR, 8'h02);
        core.open(1'b1);
        rchk(IAR, "bank0 wr", 8'h08);
        // second reset in mid-run
        @(posedge ref_clk);
        #10;
        reset_n = 1'b0;
        repeat (2) @(posedge ref_clk);
        #10;
        reset_n = 1'b1;
        chk8("busy rst", 8'h00, {7'h00, busy});
        chk8("flag rst", 8'h00, {7'h00, write_done_flag});
        rchk(ADR, "addr rst", 8'h00);
        rchk(DAT, "data rst", 8'h00);
        rchk(IAR, "bank rst", 8'h00);
        core.open(1'b1);
        rchk(IAR, "ctrl rst", 8'h00);
        rchk(`EDAC_BP_OFFSET, "bp", 8'h01);
        core.wr(DAT, 8'hC3);
        rchk(DAT, "data rw", 8'hC3);
        // service held across the write end: set wins, then clears
        #10;
        irq_ack = 1'b1;
        core.start(8'h08, 8'h04);
        cycles();
        chk8("set wins", 8'h01, {7'h00, write_done_flag});
        @(posedge ref_clk);
        #10;
        chk8("svc clr", 8'h00, {7'h00, write_done_flag});
        irq_ack = 1'b0;
        summarize();
    end
endmodule
